// file: fewp_ctrl.sv
// Host-side controller driving the flash strobes, with Avalon-MM registers
`include "fewp_params.svh"
`default_nettype none
module fewp_ctrl
    import fewp_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq_o,
    output logic [18:0]      flash_addr_o,
    output logic [7:0]       flash_dq_o,
    output logic             flash_dq_oe_o,
    input  wire logic [7:0]  flash_dq_i,
    output logic             flash_ce_n_o,
    output logic             flash_we_n_o,
    output logic             flash_oe_n_o,
    output logic             flash_hv_addr_o,
    output logic             flash_hv_oe_o
);
    fewp_state_e state_ff;
    fewp_state_e nxt_state;
    logic [2:0]  cmd_ff;
    fewp_addr_t  addr_ff;
    fewp_data_t  wdata_ff;
    fewp_data_t  rdata_ff;
    logic [31:0] rd_ff;
    logic        wait_ff;
    logic [2:0]  irq_stat_ff;
    logic [2:0]  irq_en_ff;
    logic        irq_ff;
    logic        ce_n_ff;
    logic        we_n_ff;
    logic        oe_n_ff;
    logic        dq_oe_ff;
    logic        hv_ff;
    logic        hv_oe_ff;
    fewp_addr_t  pin_addr_ff;
    logic        win_after_ff;
    logic [7:0]  dq_s1_ff;
    logic [7:0]  dq_s2_ff;
    logic        tmr_load;
    logic [17:0] tmr_count;
    logic        tmr_busy;
    logic        tmr_exp;

    fewp_pulse_timer u_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .busy_o    (tmr_busy),
        .expire_o  (tmr_exp)
    );

    // Bus decode
    // Transfer lands at the edge that sees waitrequest low
    wire acc      = (avs_read || avs_write) && !wait_ff;
    wire idle     = (state_ff == FEWP_IDLE);
    wire wr_ctrl  = acc && avs_write && avs_address == `FEWP_REG_CTRL;
    wire go       = wr_ctrl && idle && avs_writedata[2:0] != 3'h0;
    wire wr_addr  = acc && avs_write && avs_address == `FEWP_REG_ADDR;
    wire wr_wdata = acc && avs_write && avs_address == `FEWP_REG_WDATA;
    wire wr_clr   = acc && avs_write && avs_address == `FEWP_REG_IRQ_CLR;
    wire wr_en    = acc && avs_write && avs_address == `FEWP_REG_IRQ_EN;
    wire is_prot  = (cmd_ff == `FEWP_CMD_PROTECT);
    wire is_unpr  = (cmd_ff == `FEWP_CMD_UNPROTECT);
    wire hv_cmd   = is_prot || is_unpr || cmd_ff == `FEWP_CMD_HV_VERIFY;
    wire is_wr    = (cmd_ff == `FEWP_CMD_WRITE);
    wire strobe_w = is_wr || is_prot || is_unpr;
    wire done     = (state_ff == FEWP_DONE) && !tmr_busy;
    // Window bit sampled on reads and HV verifies: set on the first read after a write, it flags a lost add
    wire win_now  = rdata_ff[`FEWP_WINDOW_BIT];
    wire lost_add = done && cmd_ff == `FEWP_CMD_READ && win_after_ff && win_now;
    wire [2:0] evt = {lost_add, done && hv_cmd, done};
    wire [18:0] sel_mask = 19'h1 << `FEWP_MODE_SEL_BIT;
    wire [18:0] pin_addr = is_unpr ? (addr_ff | sel_mask) :
                           is_prot ? (addr_ff & ~sel_mask) :
                           addr_ff;

    wire [31:0] status_w = {22'h0, win_now, rdata_ff[`FEWP_POLL_BIT],
                            !idle, 7'h0};
    wire [31:0] rd_mux =
        (avs_address == `FEWP_REG_CTRL)     ? {29'h0, cmd_ff} :
        (avs_address == `FEWP_REG_ADDR)     ? {13'h0, addr_ff} :
        (avs_address == `FEWP_REG_WDATA)    ? {24'h0, wdata_ff} :
        (avs_address == `FEWP_REG_RDATA)    ? {24'h0, rdata_ff} :
        (avs_address == `FEWP_REG_STATUS)   ? status_w :
        (avs_address == `FEWP_REG_IRQ_STAT) ? {29'h0, irq_stat_ff} :
        (avs_address == `FEWP_REG_IRQ_EN)   ? {29'h0, irq_en_ff} : 32'h0;

    // Pulse length per phase
    wire [17:0] strobe_len = is_prot ? 18'(`FEWP_WPP1_CYC) :
                             is_unpr ? 18'(`FEWP_WPP2_CYC) :
                             18'(`FEWP_STROBE_CYC);
    wire [17:0] setup_len  = hv_cmd ? 18'(`FEWP_VLHT_CYC) :
                             18'(`FEWP_STROBE_CYC);

    always_comb
    begin
        nxt_state = state_ff;
        tmr_load  = 1'b0;
        tmr_count = setup_len;
        case (state_ff)
            FEWP_IDLE:
                if (go)
                begin
                    nxt_state = FEWP_SETUP;
                end
            FEWP_SETUP:
                if (tmr_exp)
                begin
                    tmr_load  = 1'b1;
                    tmr_count = strobe_len;
                    nxt_state = FEWP_STROBE;
                end
                else if (!tmr_busy)
                    tmr_load  = 1'b1;
            FEWP_STROBE:
                if (tmr_exp)
                begin
                    nxt_state = FEWP_HOLD;
                end
            FEWP_HOLD:
                if (!tmr_busy)
                begin
                    tmr_load  = 1'b1;
                    tmr_count = 18'(`FEWP_STROBE_CYC);
                    nxt_state = FEWP_DONE;
                end
            FEWP_DONE:
                if (!tmr_busy)
                begin
                    nxt_state = FEWP_IDLE;
                end
            default:
                nxt_state = FEWP_IDLE;
        endcase
    end

    wire strobing = (state_ff == FEWP_STROBE) && tmr_busy;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= FEWP_IDLE;
            cmd_ff   <= 3'h0;
            addr_ff  <= 19'h0;
            wdata_ff <= 8'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cmd_ff   <= go ? avs_writedata[2:0] : cmd_ff;
            addr_ff  <= wr_addr ? avs_writedata[18:0] : addr_ff;
            wdata_ff <= wr_wdata ? avs_writedata[7:0] : wdata_ff;
        end
    end

    // Pin sequencing: strobes idle high, write only with output strobe high
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ce_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            dq_oe_ff <= 1'b0;
            hv_ff    <= 1'b0;
            hv_oe_ff <= 1'b0;
            pin_addr_ff <= 19'h0;
        end
        else
        begin
            hv_ff    <= !idle && hv_cmd && state_ff != FEWP_DONE;
            hv_oe_ff <= !idle && (is_prot || is_unpr)
                        && state_ff != FEWP_DONE;
            pin_addr_ff <= pin_addr;
            // Reads keep chip enable low from strobe through capture
            ce_n_ff  <= !(strobing || (!strobe_w &&
                        (state_ff == FEWP_STROBE || state_ff == FEWP_HOLD)));
            we_n_ff  <= !(strobing && strobe_w);
            oe_n_ff  <= strobe_w || idle || state_ff == FEWP_DONE;
            dq_oe_ff <= is_wr && state_ff != FEWP_IDLE
                        && state_ff != FEWP_DONE;
        end
    end

    // Two-stage input sync; only stage two feeds logic
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            dq_s1_ff <= 8'h0;
            dq_s2_ff <= 8'h0;
        end
        else
        begin
            dq_s1_ff <= flash_dq_i;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            rdata_ff     <= 8'h0;
            win_after_ff <= 1'b0;
        end
        else if (state_ff == FEWP_HOLD && !strobe_w && !tmr_busy)
        begin
            rdata_ff <= dq_s2_ff;
        end
        else if (done && cmd_ff == `FEWP_CMD_WRITE)
        begin
            win_after_ff <= 1'b1;
        end
        else if (done && cmd_ff == `FEWP_CMD_READ)
        begin
            win_after_ff <= 1'b0;
        end
    end

    // Interrupt block; set wins over clear
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_ff <= 3'h0;
            irq_en_ff   <= 3'h0;
            irq_ff      <= 1'b0;
            wait_ff     <= 1'b1;
            rd_ff       <= 32'h0;
        end
        else
        begin
            irq_stat_ff <= evt | (irq_stat_ff &
                           ~(wr_clr ? avs_writedata[2:0] : 3'h0));
            irq_en_ff   <= wr_en ? avs_writedata[2:0] : irq_en_ff;
            irq_ff      <= |(irq_stat_ff & irq_en_ff);
            wait_ff     <= !((avs_read || avs_write) && wait_ff);
            rd_ff       <= rd_mux;
        end
    end

    assign avs_readdata    = rd_ff;
    assign avs_waitrequest = wait_ff;
    assign irq_o           = irq_ff;
    assign flash_addr_o    = pin_addr_ff;
    assign flash_dq_o      = wdata_ff;
    assign flash_dq_oe_o   = dq_oe_ff;
    assign flash_ce_n_o    = ce_n_ff;
    assign flash_we_n_o    = we_n_ff;
    assign flash_oe_n_o    = oe_n_ff;
    assign flash_hv_addr_o = hv_ff;
    assign flash_hv_oe_o   = hv_oe_ff;

    chk_write_oe_high: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) !flash_we_n_o |-> flash_oe_n_o)
        else $error("write strobe low while output strobe low");
    chk_write_ce_low: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) !flash_we_n_o |-> !flash_ce_n_o)
        else $error("write strobe without chip enable");
    chk_hv_on_prot: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (!flash_we_n_o && is_prot) |-> flash_hv_addr_o)
        else $error("protect pulse without elevated voltage");
    chk_strobe_width: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $fell(flash_we_n_o) |-> !flash_we_n_o [*2])
        else $error("write strobe shorter than minimum");
    chk_irq_level: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        |(irq_stat_ff & irq_en_ff) |=> irq_o)
        else $error("irq not raised");
    chk_dq_no_read: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) flash_dq_oe_o |-> flash_oe_n_o)
        else $error("data driven during read");
    chk_idle_pins: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (idle && $past(idle)) |-> (flash_we_n_o && flash_ce_n_o))
        else $error("strobes active while idle");
    chk_bus_answer: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule // fewp_ctrl
`default_nettype wire

// file: fewp_flash_model.sv
// Behavioural flash device with single-write commands and protect pins
`include "fewp_params.svh"
`default_nettype none
module fewp_flash_model
    import fewp_pkg::*;
#(
    parameter int         WIN_NS   = 100000,
    parameter int         ERASE_NS = 20000,
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'ha5  // Arbitrary value
)
(
    input  wire logic [18:0] addr_i,
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe_o,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        hv_addr_i,
    input  wire logic        hv_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       prot;
    logic       id_mode;
    logic       erasing;
    logic       tog;
    fewp_data_t q;
    fewp_data_t last;
    time        t_add;
    time        t0;
    time        t1;
    wire wr_on = !ce_n_i && !we_n_i && oe_n_i && !hv_oe_i;
    wire hv_on = hv_addr_i && hv_oe_i && !ce_n_i && !we_n_i;
    wire drv   = !ce_n_i && !oe_n_i && we_n_i;
    initial
    begin
        prot = 1'b0;
        id_mode = 1'b0;
        erasing = 1'b0;
        tog = 1'b0;
        last = 8'h00;
        q = 8'h00;
        t_add = 0;
        t0 = 0;
        t1 = 0;
    end
    task automatic age();
        if (erasing && $time - t_add >= WIN_NS + ERASE_NS)
            erasing = 1'b0;
    endtask
    always @(posedge wr_on) t0 = $time;
    always @(posedge hv_on) t1 = $time;
    // Short strobe pulses start nothing
    always @(negedge wr_on)
    begin
        age();
        if ($time - t0 < 5)
            ;
        else if (erasing && $time - t_add >= WIN_NS)
            ;
        else if (dq_i == 8'h30 && !prot)
        begin
            erasing = 1'b1;
            t_add = $time;
        end
        else if (dq_i == 8'h90 && !erasing)
            id_mode = 1'b1;
        else if (dq_i == 8'hf0)
            id_mode = 1'b0;
    end
    always @(negedge hv_on)
        if ($time - t1 >= 5)
            prot = !addr_i[`FEWP_MODE_SEL_BIT];
    always @(posedge drv)
    begin
        age();
        tog = !tog;
        if (hv_addr_i || id_mode)
            q = addr_i[1] ? {7'h00, prot}
                : (addr_i[0] ? DEV_CODE : MFR_CODE);
        else if (erasing)
            q = {1'b0, tog, 2'b00, $time - t_add >= WIN_NS, 3'b000};
        else
            q = 8'hff;
        last = q;
    end
    // Released bus shows the inverse of the last byte
    assign dq_o    = drv ? q : ~last;
    assign dq_oe_o = drv;
endmodule // fewp_flash_model
`default_nettype wire

// file: fewp_params.svh
// Constants for the flash erase window and protect controller
`ifndef FEWP_PARAMS_SVH
`define FEWP_PARAMS_SVH
`define FEWP_REG_CTRL      4'h0
`define FEWP_REG_ADDR      4'h1
`define FEWP_REG_WDATA     4'h2
`define FEWP_REG_RDATA     4'h3
`define FEWP_REG_STATUS    4'h4
`define FEWP_REG_IRQ_STAT  4'h5
`define FEWP_REG_IRQ_CLR   4'h6
`define FEWP_REG_IRQ_EN    4'h7
`define FEWP_CMD_WRITE     3'h1
`define FEWP_CMD_READ      3'h2
`define FEWP_CMD_PROTECT   3'h3
`define FEWP_CMD_UNPROTECT 3'h4
`define FEWP_CMD_HV_VERIFY 3'h5
`define FEWP_WINDOW_BIT    3
`define FEWP_POLL_BIT      7
`define FEWP_TOGGLE_BIT    6
`define FEWP_PROT_BIT      0
`define FEWP_HV_ADDR_BIT   9
`define FEWP_MODE_SEL_BIT  6
`define FEWP_ID_SEL_BIT    1
`define FEWP_CYCLE_NS      100
`define FEWP_STROBE_NS     200
`define FEWP_STROBE_CYC    ((`FEWP_STROBE_NS+`FEWP_CYCLE_NS-1)/`FEWP_CYCLE_NS)
`define FEWP_VLHT_US       4
`define FEWP_VLHT_CYC      (`FEWP_VLHT_US*1000/`FEWP_CYCLE_NS)
`define FEWP_WPP1_US       10
`define FEWP_WPP1_CYC      (`FEWP_WPP1_US*1000/`FEWP_CYCLE_NS)
`define FEWP_WPP2_MS       12
`define FEWP_WPP2_CYC      (`FEWP_WPP2_MS*1000000/`FEWP_CYCLE_NS)
`endif

// file: fewp_pkg.sv
// Types for the flash erase window and protect controller
`default_nettype none
package fewp_pkg;
    typedef enum logic [2:0] {
        FEWP_IDLE, FEWP_SETUP, FEWP_STROBE, FEWP_HOLD, FEWP_DONE
    } fewp_state_e;
    typedef logic [18:0] fewp_addr_t;
    typedef logic [7:0]  fewp_data_t;
endpackage
`default_nettype wire

// file: fewp_pulse_timer.sv
// Down counter that times strobe, settle and protect pulses
`include "fewp_params.svh"
`default_nettype none
module fewp_pulse_timer
    import fewp_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        load_i,
    input  wire logic [17:0] count_i,
    output logic             busy_o,
    output logic             expire_o
);
    logic [17:0] cnt_ff;
    logic        exp_ff;
    wire         running = (cnt_ff != 18'h0);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= 18'h0;
            exp_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= load_i ? count_i : (running ? cnt_ff - 18'h1 : cnt_ff);
            exp_ff <= !load_i && (cnt_ff == 18'h1);
        end
    end

    assign busy_o   = running;
    assign expire_o = exp_ff;
endmodule // fewp_pulse_timer
`default_nettype wire

// file: tb.sv
// Testbench for the flash controller over its Avalon-MM registers
`include "fewp_params.svh"
`default_nettype none
module tb;
    import fewp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq_o;
    fewp_addr_t  f_addr;
    fewp_data_t  c_dq;
    fewp_data_t  m_dq;
    logic        c_oe;
    logic        m_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        hv_a;
    logic        hv_o;
    logic [31:0] d;
    logic [31:0] d2;
    int          n_errors = 0;
    int          n_compared = 0;
    wire [7:0] dq_w = c_oe ? c_dq : m_dq;
    always #50 ref_clk_i = ~ref_clk_i;
    fewp_ctrl fewp_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq_o(irq_o), .flash_addr_o(f_addr), .flash_dq_o(c_dq),
        .flash_dq_oe_o(c_oe), .flash_dq_i(dq_w), .flash_ce_n_o(ce_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
        .flash_hv_addr_o(hv_a), .flash_hv_oe_o(hv_o));
    fewp_flash_model fewp_flash_model_i (.addr_i(f_addr), .dq_i(dq_w),
        .dq_o(m_dq), .dq_oe_o(m_oe), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .hv_addr_i(hv_a), .hv_oe_i(hv_o));
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic av(input logic rd, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rdd);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge ref_clk_i);
        while (avs_waitrequest !== 1'b0 && k < 50)
        begin
            @(posedge ref_clk_i);
            k++;
        end
        rdd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk_i);
        if (k >= 50)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic op(input logic [2:0] c, input logic [18:0] a,
                      input logic [7:0] w);
        logic [31:0] s;
        int          k;
        av(1'b0, `FEWP_REG_ADDR, {13'h0, a}, s);
        av(1'b0, `FEWP_REG_WDATA, {24'h0, w}, s);
        av(1'b0, `FEWP_REG_CTRL, {29'h0, c}, s);
        s = 32'h80;
        for (k = 0; k < 3000 && s[7] !== 1'b0; k++)
            av(1'b1, `FEWP_REG_STATUS, 32'h0, s);
        if (k >= 3000)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [18:0] a, output logic [31:0] r);
        op(`FEWP_CMD_READ, a, 8'h00);
        av(1'b1, `FEWP_REG_RDATA, 32'h0, r);
    endtask
    initial
    begin
        repeat (90000) @(posedge ref_clk_i);
        n_errors++;
        tally_and_finish();
    end
    always @(posedge ref_clk_i)
        if (c_oe && m_oe)
        begin
            n_errors++;
            $display("MISMATCH %0t data bus driven by both", $time);
        end
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        av(1'b1, `FEWP_REG_IRQ_STAT, 32'h0, d);
        cmp(d, 32'h0);
        cmp({31'h0, irq_o}, 32'h0);
        av(1'b1, 4'h9, 32'h0, d);
        cmp(d, 32'h0);
        // Interrupt raised, cleared, then masked
        av(1'b0, `FEWP_REG_IRQ_EN, 32'h1, d);
        op(`FEWP_CMD_WRITE, 19'h00555, 8'h90);
        cmp({31'h0, irq_o}, 32'h1);
        av(1'b1, `FEWP_REG_IRQ_STAT, 32'h0, d);
        cmp(d & 32'h1, 32'h1);
        av(1'b0, `FEWP_REG_IRQ_CLR, 32'h7, d);
        av(1'b0, `FEWP_REG_IRQ_EN, 32'h0, d);
        cmp({31'h0, irq_o}, 32'h0);
        rd(19'h00002, d);
        cmp(d, 32'h0);
        cmp({31'h0, irq_o}, 32'h0);
        rd(19'h00000, d);
        cmp(d, 32'h5a);
        op(`FEWP_CMD_WRITE, 19'h00000, 8'hf0);
        // Erase window, added sector, ignored command
        op(`FEWP_CMD_WRITE, 19'h10000, 8'h30);
        rd(19'h10000, d);
        rd(19'h10000, d2);
        cmp(d & 32'h8f, 32'h0);
        cmp((d ^ d2) & 32'h40, 32'h40);
        repeat (500) @(posedge ref_clk_i);
        op(`FEWP_CMD_WRITE, 19'h20000, 8'h30);
        repeat (700) @(posedge ref_clk_i);
        rd(19'h10000, d);
        cmp(d & 32'h88, 32'h0);
        av(1'b1, `FEWP_REG_IRQ_STAT, 32'h0, d);
        cmp(d & 32'h4, 32'h0);
        repeat (400) @(posedge ref_clk_i);
        op(`FEWP_CMD_WRITE, 19'h00555, 8'h90);
        rd(19'h00002, d);
        cmp(d & 32'h88, 32'h8);
        av(1'b1, `FEWP_REG_IRQ_STAT, 32'h0, d);
        cmp(d & 32'h4, 32'h4);
        repeat (300) @(posedge ref_clk_i);
        rd(19'h10000, d);
        cmp(d, 32'hff);
        // Protect, verify, then erase refused
        op(`FEWP_CMD_PROTECT, 19'h00000, 8'h00);
        op(`FEWP_CMD_HV_VERIFY, 19'h7fffe, 8'h00);
        av(1'b1, `FEWP_REG_RDATA, 32'h0, d);
        cmp(d, 32'h1);
        av(1'b1, `FEWP_REG_IRQ_STAT, 32'h0, d);
        cmp(d & 32'h2, 32'h2);
        op(`FEWP_CMD_WRITE, 19'h00555, 8'h90);
        rd(19'h00002, d);
        cmp(d, 32'h1);
        op(`FEWP_CMD_WRITE, 19'h00000, 8'hf0);
        op(`FEWP_CMD_WRITE, 19'h10000, 8'h30);
        rd(19'h10000, d);
        cmp(d, 32'hff);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
